// [rtl/ccu_capture_compare_unit.v]
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ccu_defines.vh"

module ccu_capture_compare_unit #(
   parameter NUM_MOD = 2,
   parameter TB_WIDTH = 16
) (
   // Clock, reset and clock enable.
   input wire clk,
   input wire sys_rst,
   input wire ce,
   // Classic Wishbone slave.
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Timebase counts and timebase control outputs.
   input wire [TB_WIDTH-1:0] timebase_a_count,
   input wire [TB_WIDTH-1:0] timebase_c_count,
   output reg timebase_a_high_wr,
   output reg [7:0] timebase_a_high_wdata,
   output reg [NUM_MOD-1:0] special_event,
   output wire [NUM_MOD-1:0] module_uses_timebase_c,
   output wire [2:0] enhanced_uses_timebase_a,
   // Module pins, port latches and direction bits.
   input wire [NUM_MOD-1:0] pin_in,
   output wire [NUM_MOD-1:0] pin_out,
   output wire [NUM_MOD-1:0] pin_oe,
   input wire [NUM_MOD-1:0] pin_direction_bit,
   input wire [NUM_MOD-1:0] port_latch,
   // Event flags and their gated requests.
   output wire [NUM_MOD-1:0] module_event_flag,
   output wire [NUM_MOD-1:0] module_event_req
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode and shared registers.

   reg [7:0] timebase_c_control_r;
   reg [7:0] shared_config_register_r;
   reg [7:0] open_drain_control_r;
   reg [NUM_MOD-1:0] module_event_irq_enable_r;
   reg [NUM_MOD-1:0] flag_r;
   reg [NUM_MOD-1:0] flag_nxt;
   reg [31:0] rdata_nxt;
   reg hit_nxt;
   wire [1:0] timer_routing_select;
   wire alternate_reg_select;
   wire wb_acc;
   wire wb_wr;
   wire [TB_WIDTH-1:0] tb_sel [0:NUM_MOD-1];
   wire [7:0] ctrl_rd [0:NUM_MOD-1];
   wire [7:0] low_rd [0:NUM_MOD-1];
   wire [7:0] high_rd [0:NUM_MOD-1];
   wire [NUM_MOD-1:0] event_set;
   wire [NUM_MOD-1:0] special_nxt;

   // Every register sits in its own 32-bit word and only the low byte carries data.
   // The acknowledge is registered, so each access is answered one cycle after it is
   // taken, and the request is masked while ack is high so that a strobe held over the
   // ack cycle is never taken twice.
   assign wb_acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr = wb_acc & wb_we_i & wb_sel_i[0];
   // The routing field is split over two control bits that are not adjacent.
   assign timer_routing_select = {timebase_c_control_r[`CCU_TBC_ROUTE_HI_BIT],
                                  timebase_c_control_r[`CCU_TBC_ROUTE_LO_BIT]};
   assign alternate_reg_select = shared_config_register_r[`CCU_CFG_ALT_SEL_BIT];

   // The enhanced modules live outside this block, but their timebase choice follows
   // from the same routing field, so it is exported for them here.
   // Enhanced routing.
   assign enhanced_uses_timebase_a[0] = (timer_routing_select != `CCU_ROUTE_ALL_C);
   assign enhanced_uses_timebase_a[1] = (timer_routing_select == `CCU_ROUTE_ALL_A) |
                                        (timer_routing_select == `CCU_ROUTE_ENH12);
   assign enhanced_uses_timebase_a[2] = (timer_routing_select == `CCU_ROUTE_ALL_A);

   // The request is the flag gated by its enable; the flag itself is set whatever the
   // enable, so software can always poll it.
   assign module_event_flag = flag_r;
   assign module_event_req = flag_r & module_event_irq_enable_r;

   // Read mux and unmapped decode.
   // Unmapped addresses are still acknowledged so that a stray access cannot hang the
   // bus, but they read zero and ignore writes.
   always @* begin
      rdata_nxt = 32'h0000_0000;
      hit_nxt = 1'b1;
      case (wb_adr_i)
         `CCU_OFS_MOD4_CTRL: rdata_nxt[7:0] = ctrl_rd[0];
         `CCU_OFS_MOD4_LOW: rdata_nxt[7:0] = low_rd[0];
         `CCU_OFS_MOD4_HIGH: rdata_nxt[7:0] = high_rd[0];
         `CCU_OFS_MOD5_CTRL: rdata_nxt[7:0] = ctrl_rd[1];
         `CCU_OFS_MOD5_LOW: rdata_nxt[7:0] = low_rd[1];
         `CCU_OFS_MOD5_HIGH: rdata_nxt[7:0] = high_rd[1];
         `CCU_OFS_TBC_CTRL: rdata_nxt[7:0] = timebase_c_control_r;
         `CCU_OFS_TBA_HIGH: rdata_nxt[7:0] = alternate_reg_select ?
                                             open_drain_control_r :
                                             timebase_a_count[15:8];
         `CCU_OFS_SHARED_CFG: rdata_nxt[7:0] = shared_config_register_r;
         `CCU_OFS_FLAGS: rdata_nxt[NUM_MOD-1:0] = flag_r;
         `CCU_OFS_IRQ_EN: rdata_nxt[NUM_MOD-1:0] = module_event_irq_enable_r;
         default: hit_nxt = 1'b0;
      endcase
      if (!hit_nxt) begin
         rdata_nxt = 32'h0000_0000;
      end
   end

   // Flags: a hardware set beats a simultaneous software clear.
   // Only software clears a flag, by writing a one to its bit. An event that lands in
   // the same cycle as the clear must not be lost, so the set is applied last.
   always @* begin
      flag_nxt = flag_r;
      if (wb_wr && wb_adr_i == `CCU_OFS_FLAGS) begin
         flag_nxt = flag_r & ~wb_dat_i[NUM_MOD-1:0];
      end
      flag_nxt = flag_nxt | event_set;
   end

   // The whole block holds still while ce is low, the acknowledge included, so a bus
   // master sees a longer wait rather than a lost access.
   always @(posedge clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         timebase_c_control_r <= `CCU_RST_TBC;
         shared_config_register_r <= `CCU_RST_CFG;
         open_drain_control_r <= `CCU_RST_OD;
         module_event_irq_enable_r <= {NUM_MOD{1'b0}};
         flag_r <= {NUM_MOD{1'b0}};
         timebase_a_high_wr <= 1'b0;
         timebase_a_high_wdata <= 8'h00;
         special_event <= {NUM_MOD{1'b0}};
      end else if (ce) begin
         wb_ack_o <= wb_acc;
         wb_dat_o <= wb_acc ? rdata_nxt : 32'h0000_0000;
         flag_r <= flag_nxt;
         special_event <= special_nxt;
         timebase_a_high_wr <= 1'b0;
         if (wb_wr) begin
            case (wb_adr_i)
               `CCU_OFS_TBC_CTRL: timebase_c_control_r <= wb_dat_i[7:0];
               `CCU_OFS_SHARED_CFG: shared_config_register_r <= wb_dat_i[7:0];
               `CCU_OFS_IRQ_EN: module_event_irq_enable_r <= wb_dat_i[NUM_MOD-1:0];
               // The first timebase lives outside this block; a write to its high
               // byte leaves as a one-cycle strobe with the byte, unless the alternate
               // select bit redirects the address to the open-drain register.
               // Alternate register reach.
               `CCU_OFS_TBA_HIGH: begin
                  if (alternate_reg_select) begin
                     open_drain_control_r <= wb_dat_i[7:0];
                  end else begin
                     timebase_a_high_wr <= 1'b1;
                     timebase_a_high_wdata <= wb_dat_i[7:0];
                  end
               end
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-module capture and compare logic.

   // Each module owns a control register, a data pair, an edge prescaler and a compare
   // output latch. The pin level is sampled every cycle, whatever the mode, so that
   // entering capture mode never sees a stale level and raises a false edge.
   // Module four is index 0 and module five index 1 throughout this file.
   genvar g;
   generate
      for (g = 0; g < NUM_MOD; g = g + 1) begin : mod
         // Offsets are summed at full width and cut back to the bus address width.
         localparam [31:0] CTRL_SUM = `CCU_OFS_MOD4_CTRL + g * `CCU_MOD_STRIDE;
         localparam [31:0] LOW_SUM = `CCU_OFS_MOD4_LOW + g * `CCU_MOD_STRIDE;
         localparam [31:0] HIGH_SUM = `CCU_OFS_MOD4_HIGH + g * `CCU_MOD_STRIDE;
         localparam [7:0] CTRL_OFS = CTRL_SUM[7:0];
         localparam [7:0] LOW_OFS = LOW_SUM[7:0];
         localparam [7:0] HIGH_OFS = HIGH_SUM[7:0];
         reg [5:0] module_control_reg_r;
         reg [7:0] module_data_low_r;
         reg [7:0] module_data_high_r;
         reg [3:0] presc_r;
         reg level_r;
         reg match_r;
         reg cmp_latch_r;
         wire [3:0] mode;
         wire [TB_WIDTH-1:0] module_data_pair;
         wire is_capture;
         wire is_compare;
         wire is_pin_compare;
         wire level;
         wire rise;
         wire fall;
         wire cap_evt;
         wire match;
         wire match_evt;
         wire ctrl_wr;
         wire od;
         wire drive_val;

         assign mode = module_control_reg_r[`CCU_CTRL_MODE_HI:0];
         assign module_data_pair = {module_data_high_r, module_data_low_r};
         // Capture modes are 01xx; the compare modes that own the pin are 0010, 1000, 1001.
         assign is_capture = (mode[3:2] == 2'b01);
         assign is_pin_compare = (mode == `CCU_MODE_CMP_TOGGLE) ||
                                 (mode == `CCU_MODE_CMP_SET) ||
                                 (mode == `CCU_MODE_CMP_CLR);
         assign is_compare = is_pin_compare || (mode == `CCU_MODE_CMP_SOFT) ||
                             (mode == `CCU_MODE_CMP_SPECIAL);
         assign ctrl_wr = wb_wr && (wb_adr_i == CTRL_OFS);

         // Both standard modules stay on the first timebase only when routing is 00;
         // any other routing moves them to the third one together.
         // Capture/compare timebase.
         assign module_uses_timebase_c[g] = (timer_routing_select != `CCU_ROUTE_ALL_A);
         assign tb_sel[g] = module_uses_timebase_c[g] ? timebase_c_count :
                                                        timebase_a_count;

         // An open-drain pin never drives high: a one releases the driver and lets the
         // external pull-up set the level. The bit acts only in modes that own the pin.
         // Open-drain driver.
         assign od = open_drain_control_r[`CCU_OD_MOD4_BIT + g] & is_pin_compare;
         assign drive_val = is_pin_compare ? cmp_latch_r : port_latch[g];
         assign pin_out[g] = od ? 1'b0 : drive_val;
         assign pin_oe[g] = ~pin_direction_bit[g] & ~(od & drive_val);

         // When the pin is an output, capture watches the driven value, so a write to
         // the port latch can cause a capture. A released open-drain pin counts as high.
         // Output pin seen by capture.
         assign level = pin_oe[g] ? pin_out[g] : (od ? 1'b1 : pin_in[g]);
         assign rise = level & ~level_r;
         assign fall = ~level & level_r;

         // The prescaler counts every rising edge while in a capture mode. It is not
         // cleared when one capture mode replaces another, so the first capture after
         // such a switch may come early; software should turn the module off first.
         // Event choice.
         assign cap_evt = is_capture &&
            (((mode == `CCU_MODE_CAP_FALL) && fall) ||
             ((mode == `CCU_MODE_CAP_RISE) && rise) ||
             ((mode == `CCU_MODE_CAP_RISE4) && rise && presc_r[1:0] == `CCU_PS4_LAST) ||
             ((mode == `CCU_MODE_CAP_RISE16) && rise && presc_r == `CCU_PS16_LAST));

         // A match is acted on once, in the first cycle of equality. A timebase that
         // stops on the compare value would otherwise toggle the pin every cycle.
         // A control write re-arms the detector.
         // Continuous compare.
         assign match = is_compare && (module_data_pair == tb_sel[g]);
         assign match_evt = match & ~match_r;

         assign event_set[g] = cap_evt | match_evt;
         // The special event is only a pulse; resetting the timebase and starting a
         // conversion are left to the blocks that own them.
         // Special event pulse.
         assign special_nxt[g] = match_evt && (mode == `CCU_MODE_CMP_SPECIAL);

         // Bits 7:6 of the control register are not implemented and read zero.
         assign ctrl_rd[g] = {2'b00, module_control_reg_r};
         assign low_rd[g] = module_data_low_r;
         assign high_rd[g] = module_data_high_r;

         always @(posedge clk) begin
            if (sys_rst) begin
               module_control_reg_r <= 6'h00;
               module_data_low_r <= `CCU_RST_DATA;
               module_data_high_r <= `CCU_RST_DATA;
               presc_r <= 4'h0;
               level_r <= 1'b0;
               match_r <= 1'b0;
               cmp_latch_r <= 1'b0;
            end else if (ce) begin
               // Edges compare this level with the one of the cycle before, so a
               // capture lands on the same clock edge that first samples the pin change.
               level_r <= level;
               match_r <= match;
               if (wb_wr && wb_adr_i == LOW_OFS) begin
                  module_data_low_r <= wb_dat_i[7:0];
               end
               if (wb_wr && wb_adr_i == HIGH_OFS) begin
                  module_data_high_r <= wb_dat_i[7:0];
               end
               // A capture that meets a software write to a data byte wins, as the
               // newer count is the one software asked to see.
               // Capture copy.
               if (cap_evt) begin
                  module_data_low_r <= tb_sel[g][7:0];
                  module_data_high_r <= tb_sel[g][15:8];
               end
               if (!is_capture) begin
                  presc_r <= 4'h0;
               end else if (rise) begin
                  presc_r <= presc_r + 4'h1;
               end
               if (match_evt) begin
                  case (mode)
                     `CCU_MODE_CMP_TOGGLE: cmp_latch_r <= ~cmp_latch_r;
                     `CCU_MODE_CMP_SET: cmp_latch_r <= 1'b1;
                     `CCU_MODE_CMP_CLR: cmp_latch_r <= 1'b0;
                     default: ;
                  endcase
               end
               if (ctrl_wr) begin
                  module_control_reg_r <= wb_dat_i[`CCU_CTRL_USED_HI:0];
                  match_r <= 1'b0;
                  // Writing the set or clear compare mode loads the start level of the latch at once; toggle keeps it.
                  case (wb_dat_i[`CCU_CTRL_MODE_HI:0])
                     `CCU_MODE_CMP_SET: cmp_latch_r <= 1'b0;
                     `CCU_MODE_CMP_CLR: cmp_latch_r <= 1'b1;
                     `CCU_MODE_OFF: begin
                        cmp_latch_r <= 1'b0;
                        presc_r <= 4'h0;
                     end
                     default: ;
                  endcase
               end
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// [rtl/ccu_defines.vh]
`ifndef CCU_DEFINES_VH
`define CCU_DEFINES_VH

// Register byte offsets on the bus.
`define CCU_OFS_MOD4_CTRL 8'h00
`define CCU_OFS_MOD4_LOW 8'h04
`define CCU_OFS_MOD4_HIGH 8'h08
`define CCU_OFS_MOD5_CTRL 8'h0C
`define CCU_OFS_MOD5_LOW 8'h10
`define CCU_OFS_MOD5_HIGH 8'h14
`define CCU_OFS_TBC_CTRL 8'h18
`define CCU_OFS_TBA_HIGH 8'h1C
`define CCU_OFS_SHARED_CFG 8'h20
`define CCU_OFS_FLAGS 8'h24
`define CCU_OFS_IRQ_EN 8'h28
`define CCU_MOD_STRIDE 8'h0C

// Field positions.
`define CCU_CTRL_MODE_HI 3
`define CCU_CTRL_USED_HI 5
`define CCU_TBC_ROUTE_HI_BIT 6
`define CCU_TBC_ROUTE_LO_BIT 3
`define CCU_CFG_ALT_SEL_BIT 4
`define CCU_OD_MOD4_BIT 3

// Reset values.
`define CCU_RST_CTRL 8'h00
`define CCU_RST_DATA 8'h00
`define CCU_RST_TBC 8'h00
`define CCU_RST_CFG 8'h00
`define CCU_RST_OD 8'h00

// Mode field encodings.
`define CCU_MODE_OFF 4'h0
`define CCU_MODE_CMP_TOGGLE 4'h2
`define CCU_MODE_CAP_FALL 4'h4
`define CCU_MODE_CAP_RISE 4'h5
`define CCU_MODE_CAP_RISE4 4'h6
`define CCU_MODE_CAP_RISE16 4'h7
`define CCU_MODE_CMP_SET 4'h8
`define CCU_MODE_CMP_CLR 4'h9
`define CCU_MODE_CMP_SOFT 4'hA
`define CCU_MODE_CMP_SPECIAL 4'hB

// Timer routing select values.
`define CCU_ROUTE_ALL_A 2'h0
`define CCU_ROUTE_ENH1 2'h1
`define CCU_ROUTE_ENH12 2'h2
`define CCU_ROUTE_ALL_C 2'h3

// Prescaler terminal counts.
`define CCU_PS4_LAST 2'h3
`define CCU_PS16_LAST 4'hF

`endif

// [testbench/ccu_capture_compare_unit_props.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ccu_defines.vh"
module ccu_cc_props #(
   parameter NUM_MOD = 2,
   parameter TB_WIDTH = 16
) (
   // Clock and reset.
   input wire clk,
   input wire sys_rst,
   // Bus.
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // Timebase, routing and events.
   input wire timebase_a_high_wr,
   input wire [7:0] timebase_a_high_wdata,
   input wire [NUM_MOD-1:0] special_event,
   input wire [NUM_MOD-1:0] module_uses_timebase_c,
   input wire [2:0] enhanced_uses_timebase_a,
   input wire [NUM_MOD-1:0] module_event_flag,
   input wire [NUM_MOD-1:0] module_event_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   flag_sticky_a: assert property (|($past(module_event_flag) & ~module_event_flag)
      |-> $past(wb_we_i) && $past(wb_stb_i))
      else $error("event flag cleared without a write");
   tb_write_a: assert property (timebase_a_high_wr |-> $past(wb_we_i)
      && $past(wb_adr_i) == `CCU_OFS_TBA_HIGH
      && {24'h0, timebase_a_high_wdata} == ($past(wb_dat_i) & 32'h0000_00FF))
      else $error("timebase high write without bus write");
   special_pulse_a: assert property (|special_event |=> special_event == '0)
      else $error("special event longer than one cycle");
   special_flag_a: assert property ((special_event & ~module_event_flag) == '0)
      else $error("special event without flag");
   req_gate_a: assert property ((module_event_req & ~module_event_flag) == '0)
      else $error("request without flag");
   route_share_a: assert property (module_uses_timebase_c
      == {NUM_MOD{~enhanced_uses_timebase_a[2]}})
      else $error("standard modules off shared timebase");
   route_all_a: assert property (enhanced_uses_timebase_a[1] |-> enhanced_uses_timebase_a[0])
      else $error("enhanced two routed without one");
endmodule
bind ccu_capture_compare_unit ccu_cc_props #(.NUM_MOD(NUM_MOD), .TB_WIDTH(TB_WIDTH)) i_props (
   .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .timebase_a_high_wr(timebase_a_high_wr),
   .timebase_a_high_wdata(timebase_a_high_wdata), .special_event(special_event),
   .module_uses_timebase_c(module_uses_timebase_c),
   .enhanced_uses_timebase_a(enhanced_uses_timebase_a),
   .module_event_flag(module_event_flag), .module_event_req(module_event_req)
);
`default_nettype wire

// [testbench/ccu_pin_source.sv]
`timescale 1ns/10ps
`default_nettype none
module ccu_pin_source (
   // Far-side source.
   input wire logic [1:0] src_level,
   input wire logic src_en,
   // Module pin driver.
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe,
   output logic [1:0] pin_in
);
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : (src_en ? src_level[i] : 1'b1);
      end
   end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ccu_defines.vh"
module tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic src_en = 1'b1;
   logic ce = 1'b1;
   logic [3:0] sel = 4'hF;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = '0;
   logic [31:0] rdat, dat_o;
   logic ack, tba_wr;
   logic [7:0] tba_wd;
   logic [15:0] tba = 16'h0000;
   logic [15:0] tbc = 16'h0000;
   logic [1:0] src = 2'h0;
   logic [1:0] dir = 2'h3;
   logic [1:0] latch = 2'h0;
   logic [1:0] spec_seen = 2'h0;
   logic wr_seen = 1'b0;
   logic [1:0] pin_in, pin_out, pin_oe, spec, use_c, flag, req;
   logic [2:0] enh;
   int n_fail = 0;
   int n_tests = 0;
   int cycles = 0;
   ccu_capture_compare_unit i_dut (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .timebase_a_count(tba), .timebase_c_count(tbc), .timebase_a_high_wr(tba_wr),
      .timebase_a_high_wdata(tba_wd), .special_event(spec), .module_uses_timebase_c(use_c),
      .enhanced_uses_timebase_a(enh), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_direction_bit(dir), .port_latch(latch), .module_event_flag(flag),
      .module_event_req(req)
   );
   ccu_pin_source i_src (.src_level(src), .src_en(src_en), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_in(pin_in));
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) begin
      spec_seen <= spec_seen | spec;
      wr_seen <= wr_seen | tba_wr;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, '0);
      chk(nm, e, rdat);
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [7:0] ofs [4];
      ofs = '{`CCU_OFS_MOD4_LOW, `CCU_OFS_MOD4_HIGH, `CCU_OFS_MOD5_LOW, `CCU_OFS_MOD5_HIGH};
      rchk("flags rst", `CCU_OFS_FLAGS, '0);
      chk("oe rst", {30'h0, ~dir}, {30'h0, pin_oe});
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, ofs[i], 32'h0000_A5C0 + i);
         rchk("data", ofs[i], 32'h0000_00C0 + i);
      end
      sel <= 4'hE;
      wb(1'b1, `CCU_OFS_MOD4_LOW, 32'h0000_0011);
      sel <= 4'hF;
      rchk("sel gate", `CCU_OFS_MOD4_LOW, 32'h0000_00C0);
      wb(1'b1, `CCU_OFS_MOD5_CTRL, 32'h0000_00EA);
      rchk("ctrl", `CCU_OFS_MOD5_CTRL, 32'h0000_002A);
      wb(1'b1, 8'h3C, 32'h0000_00FF);
      rchk("unmapped", 8'h3C, '0);
      wb(1'b1, `CCU_OFS_MOD5_CTRL, '0);
   endtask
   task automatic t_route();
      logic [2:0] exp_enh [4];
      exp_enh = '{3'h7, 3'h1, 3'h3, 3'h0};
      for (int r = 0; r < 4; r++) begin
         wb(1'b1, `CCU_OFS_TBC_CTRL, {25'h0, r[1], 2'h0, r[0], 3'h0});
         chk("enh route", {29'h0, exp_enh[r]}, {29'h0, enh});
         chk("std route", (r == 0) ? 32'h0 : 32'h3, {30'h0, use_c});
      end
   endtask
   task automatic t_capture();
      wb(1'b1, `CCU_OFS_TBC_CTRL, '0);
      wb(1'b1, `CCU_OFS_MOD4_CTRL, {28'h0, `CCU_MODE_CAP_RISE});
      wb(1'b1, `CCU_OFS_FLAGS, 32'h3);
      wb(1'b1, `CCU_OFS_IRQ_EN, 32'h1);
      tba <= 16'h1234;
      src[0] <= 1'b1;
      settle();
      tba <= 16'hBEEF;
      src[0] <= 1'b0;
      settle();
      rchk("cap low", `CCU_OFS_MOD4_LOW, 32'h34);
      rchk("cap high", `CCU_OFS_MOD4_HIGH, 32'h12);
      chk("req", 32'h1, {31'h0, req[0]});
      src[0] <= 1'b1;
      settle();
      rchk("overwrite", `CCU_OFS_MOD4_HIGH, 32'hBE);
      rchk("flag held", `CCU_OFS_FLAGS, 32'h1);
      wb(1'b1, `CCU_OFS_FLAGS, 32'h1);
      rchk("flag clr", `CCU_OFS_FLAGS, '0);
      wb(1'b1, `CCU_OFS_MOD4_CTRL, {28'h0, `CCU_MODE_CAP_FALL});
      tba <= 16'h0777;
      src[0] <= 1'b0;
      settle();
      rchk("fall cap", `CCU_OFS_MOD4_LOW, 32'h77);
      dir[1] <= 1'b0;
      wb(1'b1, `CCU_OFS_MOD5_CTRL, {28'h0, `CCU_MODE_CAP_RISE});
      tba <= 16'h0456;
      latch[1] <= 1'b1;
      settle();
      rchk("latch cap", `CCU_OFS_MOD5_LOW, 32'h56);
      wb(1'b1, `CCU_OFS_MOD5_CTRL, '0);
   endtask
   task automatic t_enable();
      wb(1'b1, `CCU_OFS_MOD4_CTRL, {28'h0, `CCU_MODE_CAP_RISE});
      wb(1'b1, `CCU_OFS_FLAGS, 32'h3);
      ce <= 1'b0;
      tba <= 16'h0A0B;
      src[0] <= 1'b1;
      settle();
      chk("ce frozen", '0, {31'h0, flag[0]});
      ce <= 1'b1;
      settle();
      rchk("ce resume", `CCU_OFS_MOD4_LOW, 32'h0B);
      src[0] <= 1'b0;
      settle();
   endtask
   task automatic t_prescale();
      logic [3:0] modes [2];
      int cnt [2];
      modes = '{`CCU_MODE_CAP_RISE4, `CCU_MODE_CAP_RISE16};
      cnt = '{4, 16};
      wb(1'b1, `CCU_OFS_TBC_CTRL, 32'h48);
      tba <= 16'hFFFF;
      for (int m = 0; m < 2; m++) begin
         wb(1'b1, `CCU_OFS_MOD4_CTRL, '0);
         wb(1'b1, `CCU_OFS_MOD4_CTRL, {28'h0, modes[m]});
         wb(1'b1, `CCU_OFS_FLAGS, 32'h3);
         for (int k = 1; k <= cnt[m]; k++) begin
            tbc <= 16'(k);
            src[0] <= 1'b1;
            settle();
            src[0] <= 1'b0;
            settle();
            if (k == cnt[m] - 1) rchk("ps early", `CCU_OFS_FLAGS, '0);
         end
         rchk("ps count", `CCU_OFS_MOD4_LOW, cnt[m]);
      end
   endtask
   task automatic t_compare();
      logic [3:0] modes [5];
      logic [4:0] pre, post;
      modes = '{`CCU_MODE_CMP_SET, `CCU_MODE_CMP_CLR, `CCU_MODE_CMP_TOGGLE,
         `CCU_MODE_CMP_SOFT, `CCU_MODE_CMP_SPECIAL};
      pre = 5'b01010;
      post = 5'b01101;
      wb(1'b1, `CCU_OFS_TBC_CTRL, '0);
      dir[0] <= 1'b0;
      latch[0] <= 1'b1;
      wb(1'b1, `CCU_OFS_MOD4_LOW, 32'h50);
      wb(1'b1, `CCU_OFS_MOD4_HIGH, '0);
      for (int i = 0; i < 5; i++) begin
         tba <= 16'h004F;
         wb(1'b1, `CCU_OFS_MOD4_CTRL, '0);
         wb(1'b1, `CCU_OFS_MOD4_CTRL, {28'h0, modes[i]});
         wb(1'b1, `CCU_OFS_FLAGS, 32'h1);
         if (i < 4) chk("cmp start", {31'h0, pre[i]}, {31'h0, pin_out[0]});
         tba <= 16'h0050;
         settle();
         if (i < 4) chk("cmp match", {31'h0, post[i]}, {31'h0, pin_out[0]});
         chk("cmp flag", 32'h1, {31'h0, flag[0]});
         chk("special", {31'h0, i == 4}, {31'h0, spec_seen[0]});
      end
      tba <= 16'h004F;
      wb(1'b1, `CCU_OFS_MOD4_CTRL, {28'h0, `CCU_MODE_CMP_CLR});
      wb(1'b1, `CCU_OFS_MOD4_CTRL, '0);
      chk("off pin", 32'h1, {31'h0, pin_out[0]});
      wb(1'b1, `CCU_OFS_MOD4_CTRL, {28'h0, `CCU_MODE_CMP_TOGGLE});
      chk("latch low", '0, {31'h0, pin_out[0]});
   endtask
   task automatic t_open_drain();
      latch[0] <= 1'b0;
      wb(1'b1, `CCU_OFS_SHARED_CFG, 32'h10);
      wb(1'b1, `CCU_OFS_TBA_HIGH, 32'h08);
      rchk("od reg", `CCU_OFS_TBA_HIGH, 32'h08);
      chk("no tb wr", '0, {31'h0, wr_seen});
      src_en <= 1'b0;
      wb(1'b1, `CCU_OFS_MOD4_CTRL, {28'h0, `CCU_MODE_CMP_SET});
      chk("od low", '0, {31'h0, pin_in[0]});
      tba <= 16'h0050;
      settle();
      chk("od oe", '0, {31'h0, pin_oe[0]});
      chk("od pullup", 32'h1, {31'h0, pin_in[0]});
      wb(1'b1, `CCU_OFS_SHARED_CFG, '0);
      wb(1'b1, `CCU_OFS_TBA_HIGH, 32'h77);
      chk("tb wr", 32'h1, {31'h0, wr_seen});
      chk("tb data", 32'h77, {24'h0, tba_wd});
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_route();
      t_capture();
      t_enable();
      t_prescale();
      t_compare();
      t_open_drain();
      results();
   end
endmodule
`default_nettype wire
